// ---- hdl/psr_top.sv ----
// Management frame engine with status flags and identifier words
module psr_top import psr_pkg::*; #(
  parameter logic [23:0] OUI   = OUI_NEUTRAL,
  parameter logic [5:0]  MODEL = MODEL_NEUTRAL,
  parameter logic [3:0]  REV   = REV_NEUTRAL
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  phy_addr,
  // Line state from the transceiver core
  input  wire psr_line_t   line_st,
  input  wire logic [15:0] lp_word,
  input  wire logic        lp_valid
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [15:0] id_high_word(input logic [23:0] oui);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      w[15-i] = oui[2+i];
    end
    return w;
  endfunction

  function automatic logic [15:0] id_low_word(input logic [23:0] oui,
                                              input logic [5:0]  model,
                                              input logic [3:0]  rev);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      w[15-i] = oui[18+i];
    end
    w[9:4] = model;
    w[3:0] = rev;
    return w;
  endfunction

  function automatic logic fault_cause(input logic [15:0] w);
    return w[LP_RFAULT_BIT]
         | (w[LP_SEL_LSB +: 5] != SEL_CSMA)
         | (w[LP_TECH_LSB +: 5] == TECH_T4_ONLY);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       mdc_m;
  logic       mdc_s;
  logic       mdc_d;
  logic       mdio_m;
  logic       mdio_s;
  logic [4:0] addr_m;
  logic [4:0] addr_s;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_m  <= 1'b0;
      mdc_s  <= 1'b0;
      mdc_d  <= 1'b0;
      mdio_m <= 1'b1;
      mdio_s <= 1'b1;
      addr_m <= 5'h00;
      addr_s <= 5'h00;
    end else begin
      mdc_m  <= mdc;
      mdc_s  <= mdc_m;
      mdc_d  <= mdc_s;
      mdio_m <= mdio_in;
      mdio_s <= mdio_m;
      addr_m <= phy_addr;
      addr_s <= addr_m;
    end
  end

  logic rise;
  assign rise = mdc_s & ~mdc_d;

  // ****************************************
  // Frame sequencer
  // ****************************************
  psr_state_t  state;
  logic [5:0]  pre_cnt;
  logic [4:0]  bit_cnt;
  logic [11:0] hdr_sh;
  psr_hdr_t    hdr;
  logic        hdr_end;
  logic        hit_read;
  logic        resp;

  assign hdr      = {hdr_sh, mdio_s};
  assign hdr_end  = rise && (state == S_HDR) && (bit_cnt == HDR_LAST);
  assign hit_read = hdr_end && hdr.st_one && (hdr.op == OP_READ) && (hdr.phy == addr_s);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= S_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
    end else if (rise) begin
      case (state)
        S_PRE: begin
          if (mdio_s) begin
            if (pre_cnt != PRE_LEN) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else if (pre_cnt == PRE_LEN) begin
            state   <= S_HDR;
            bit_cnt <= 5'h00;
          end else begin
            pre_cnt <= 6'h00;
          end
        end
        S_HDR: begin
          pre_cnt <= 6'h00;
          if (bit_cnt == HDR_LAST) begin
            bit_cnt <= 5'h00;
            state   <= hdr.st_one ? S_TA : S_PRE;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        S_TA: begin
          if (bit_cnt == 5'h01) begin
            state   <= S_DATA;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        S_DATA: begin
          if (bit_cnt == DATA_LAST) begin
            state   <= S_PRE;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: begin
          state   <= S_PRE;
          pre_cnt <= 6'h00;
          bit_cnt <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_sh <= 12'h000;
    end else if (rise && state == S_HDR) begin
      hdr_sh <= hdr[11:0];
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic clr_sts;
  logic rf_flag;
  logic lnk_fail;
  logic jab_flag;
  logic rf_evt;
  logic jab_evt;

  assign clr_sts = hit_read && (hdr.addr == REG_STATUS);
  assign rf_evt  = lp_valid && fault_cause(lp_word);
  assign jab_evt = line_st.jabber && line_st.ten_tp;

  psr_latch #(.RST_VAL(RST_RFAULT)) u_rfault (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set_evt (rf_evt),
    .clr     (clr_sts),
    .flag    (rf_flag)
  );

  psr_latch #(.RST_VAL(RST_LINK_FAIL)) u_link (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set_evt (~line_st.link_up),
    .clr     (clr_sts),
    .flag    (lnk_fail)
  );

  psr_latch #(.RST_VAL(RST_JABBER)) u_jabber (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set_evt (jab_evt),
    .clr     (clr_sts),
    .flag    (jab_flag)
  );

  logic [15:0] sts_word;
  always_comb begin
    sts_word              = 16'h0000;
    sts_word[BIT_HDRLESS] = 1'b0;
    sts_word[BIT_AN_DONE] = line_st.an_done;
    sts_word[BIT_RFAULT]  = rf_flag;
    sts_word[BIT_AN_ABLE] = 1'b1;
    sts_word[BIT_LINK]    = ~lnk_fail;
    sts_word[BIT_JABBER]  = jab_flag;
    sts_word[BIT_EXT_CAP] = 1'b1;
  end

  // ****************************************
  // Read data and pin drive
  // ****************************************
  logic [15:0] rd_sh;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sh <= 16'h0000;
      resp  <= 1'b0;
    end else if (hdr_end) begin
      resp <= hit_read;
      case (hdr.addr)
        REG_STATUS:  rd_sh <= sts_word;
        REG_ID_HIGH: rd_sh <= id_high_word(OUI);
        REG_ID_LOW:  rd_sh <= id_low_word(OUI, MODEL, REV);
        default:     rd_sh <= 16'h0000;
      endcase
    end else if (rise && (state == S_DATA || (state == S_TA && bit_cnt == 5'h01))) begin
      rd_sh <= {rd_sh[14:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (rise) begin
      if (state == S_TA && bit_cnt == 5'h00) begin
        mdio_oe  <= resp;
        mdio_out <= 1'b0;
      end else if (state == S_TA || (state == S_DATA && bit_cnt != DATA_LAST)) begin
        mdio_out <= rd_sh[15];
      end else begin
        mdio_oe  <= 1'b0;
        mdio_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_load_sts;
    hit_read && hdr.addr == REG_STATUS;
  endsequence

  sequence s_load_id(logic [4:0] a);
    hit_read && hdr.addr == a;
  endsequence

  short_pre_a: assert property (
    rise && state == S_PRE && !mdio_s && pre_cnt != PRE_LEN
    |=> state == S_PRE && pre_cnt == 6'h00) else $error("short preamble accepted");
  const_bits_a: assert property (
    s_load_sts |=> rd_sh[BIT_HDRLESS] == 1'b0 && rd_sh[BIT_AN_ABLE] && rd_sh[BIT_EXT_CAP])
    else $error("constant status bits wrong");
  an_done_a: assert property (
    s_load_sts |=> rd_sh[BIT_AN_DONE] == $past(line_st.an_done))
    else $error("negotiation done bit wrong");
  flag_snap_a: assert property (
    s_load_sts |=> rd_sh[BIT_RFAULT] == $past(rf_flag)
    && rd_sh[BIT_JABBER] == $past(jab_flag) && rd_sh[BIT_LINK] == !$past(lnk_fail))
    else $error("latched status bits wrong");
  rf_flag_bit_a: assert property (
    lp_valid && lp_word[LP_RFAULT_BIT] |=> rf_flag)
    else $error("partner fault flag not latched");
  rf_hold_a: assert property (
    rf_flag && !clr_sts |=> rf_flag) else $error("remote fault lost before read");
  rf_select_a: assert property (
    lp_valid && lp_word[LP_SEL_LSB +: 5] != SEL_CSMA |=> rf_flag)
    else $error("selector fault not latched");
  rf_t4only_a: assert property (
    lp_valid && lp_word[LP_TECH_LSB +: 5] == TECH_T4_ONLY |=> rf_flag)
    else $error("T4-only fault not latched");
  link_hold_a: assert property (
    lnk_fail && !clr_sts |=> lnk_fail) else $error("link low released early");
  link_back_a: assert property (
    clr_sts && line_st.link_up |=> !lnk_fail)
    else $error("link bit did not recover after read");
  jab_mode_a: assert property (
    line_st.jabber && !line_st.ten_tp && !jab_flag && !clr_sts |=> !jab_flag)
    else $error("jabber latched outside 10BASE-T");
  jab_hold_a: assert property (
    jab_flag && !clr_sts |=> jab_flag) else $error("jabber flag lost before read");
  id_high_a: assert property (
    s_load_id(REG_ID_HIGH) |=> rd_sh == id_high_word(OUI))
    else $error("first identifier word wrong");
  id_low_a: assert property (
    s_load_id(REG_ID_LOW) |=> rd_sh[15:10] == {OUI[18], OUI[19], OUI[20], OUI[21], OUI[22],
    OUI[23]} && rd_sh[9:4] == MODEL && rd_sh[3:0] == REV)
    else $error("second identifier word wrong");
  write_keep_a: assert property (
    hdr_end && hdr.op == OP_WRITE |-> !clr_sts) else $error("write cleared a latched flag");
  reset_again_a: assert property (
    clr_sts && jab_evt |=> jab_flag [*2]) else $error("persistent jabber not relatched");

endmodule

// ---- hdl/psr_pkg.sv ----
// Constants and types for the management status and identifier register bank
// Contract
// - Headerless frame capability reads 0; frames lacking a full preamble are ignored.
// - Negotiation-done bit reads 1 when negotiation finished, else 0.
// - Remote fault latches high when partner word carries its fault flag.
// - Remote fault latches high when partner selector is not the CSMA/CD code.
// - Remote fault latches high when partner advertises the T4 technology only.
// - Negotiation ability bit is read-only and always 1.
// - Link bit drops on link failure, stays low until read, then follows link.
// - Jabber bit counts only in 10 Mb/s twisted pair; latches high until read.
// - Extended capability bit always reads 1.
// - First identifier word returns identifier bits 3 to 18.
// - Second identifier word top six bits return identifier bits 19 to 24.
// - Second identifier word bits 9 to 4 return the model number.
// - Second identifier word low four bits return the revision.
package psr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] REG_STATUS   = 5'h01;
  localparam logic [4:0] REG_ID_HIGH  = 5'h02;
  localparam logic [4:0] REG_ID_LOW   = 5'h03;

  // Status bit positions
  localparam int BIT_HDRLESS  = 6;
  localparam int BIT_AN_DONE  = 5;
  localparam int BIT_RFAULT   = 4;
  localparam int BIT_AN_ABLE  = 3;
  localparam int BIT_LINK     = 2;
  localparam int BIT_JABBER   = 1;
  localparam int BIT_EXT_CAP  = 0;

  // Flag reset values (link failure flag starts set so the link bit reads 0)
  localparam logic RST_RFAULT    = 1'b0;
  localparam logic RST_LINK_FAIL = 1'b1;
  localparam logic RST_JABBER    = 1'b0;

  // Identity values: arbitrary neutral defaults
  localparam logic [23:0] OUI_NEUTRAL   = 24'h5A3C96;
  localparam logic [5:0]  MODEL_NEUTRAL = 6'h2A;
  localparam logic [3:0]  REV_NEUTRAL   = 4'h5;

  // ****************************************
  // Partner ability word fields
  // ****************************************
  localparam int         LP_RFAULT_BIT = 13;
  localparam int         LP_SEL_LSB    = 0;
  localparam int         LP_TECH_LSB   = 5;
  localparam logic [4:0] SEL_CSMA      = 5'h01;
  localparam logic [4:0] TECH_T4_ONLY  = 5'h10;

  // ****************************************
  // Management frame
  // ****************************************
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [4:0] HDR_LAST  = 5'h0C;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;

  typedef struct packed {
    logic an_done;
    logic link_up;
    logic jabber;
    logic ten_tp;
  } psr_line_t;

  typedef struct packed {
    logic       st_one;
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] addr;
  } psr_hdr_t;

  typedef enum logic [3:0] {
    S_PRE  = 4'h1,
    S_HDR  = 4'h2,
    S_TA   = 4'h4,
    S_DATA = 4'h8
  } psr_state_t;

endpackage

// ---- hdl/psr_latch.sv ----
// Sticky status flag that clears on a read and lets a new event win
module psr_latch import psr_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Event and read clear
  input  wire logic set_evt,
  input  wire logic clr,
  // Flag
  output logic      flag
);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= RST_VAL;
    end else begin
      flag <= set_evt | (flag & ~clr);
    end
  end

endmodule

// ---- dv/psr_mgmt_master.sv ----
// Management station model that clocks frames into the device and reads its answers
module psr_mgmt_master (
  // Clock
  input  wire logic sys_clk,
  // Device drive of the data pin
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  // Station pins
  output logic      mdc,
  output logic      mdio_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_en  = 1'b0;
  logic drv_val = 1'b1;

  // Data pin carries a pull-up, so a released wire reads high
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

  initial begin
    mdc = 1'b0;
  end

  // ****************************************
  // One management bit: low phase, sample, high phase
  // ****************************************
  task automatic bit_cyc(input logic en, input logic b, output logic s);
    drv_en  = en;
    drv_val = b;
    mdc     = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    s   = mdio_in;
    mdc = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // ****************************************
  // Whole frame; a read returns the sixteen bits seen on the wire
  // ****************************************
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] regn, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'h1, op, phy, regn};
    rd  = 16'h0000;
    for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    if (op == psr_pkg::OP_WRITE) begin
      bit_cyc(1'b1, 1'b1, s);
      bit_cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wd[i], s);
    end else begin
      // Turnaround: station releases the wire
      bit_cyc(1'b0, 1'b1, s);
      bit_cyc(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        bit_cyc(1'b0, 1'b1, s);
        rd = {rd[14:0], s};
      end
    end
    bit_cyc(1'b0, 1'b1, s);
  endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the status and identifier register bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0] ADDR = 5'h05;
  localparam logic       T    = 1'h1;
  localparam logic       F    = 1'h0;

  logic                sys_clk  = 1'b0;
  logic                arst_n   = 1'b0;
  logic                mdc;
  logic                mdio_in;
  logic                mdio_out;
  logic                mdio_oe;
  psr_pkg::psr_line_t  line_st  = '0;
  logic [15:0]         lp_word  = 16'h0000;
  logic                lp_valid = 1'b0;
  logic [15:0]         rd;
  logic [15:0]         id_hi;
  logic [15:0]         id_lo;
  logic [15:0]         lp_tab [4] = '{16'h2001, 16'h0002, 16'h0201, 16'h03E1};
  int                  miscompares = 0;
  int                  compares    = 0;

  always #10 sys_clk = ~sys_clk;

  psr_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_in),
               .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(ADDR),
               .line_st(line_st), .lp_word(lp_word), .lp_valid(lp_valid));

  psr_mgmt_master mst (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
                       .mdc(mdc), .mdio_in(mdio_in));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] stat(logic an, logic rf, logic lk, logic jb);
    return {10'h000, an, rf, 1'h1, lk, jb, 1'h1};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] regn, input logic [15:0] exp);
    mst.frame(32, psr_pkg::OP_READ, ADDR, regn, 16'h0000, rd);
    check(rd, exp);
  endtask

  task automatic wr(input logic [4:0] regn, input logic [15:0] wd);
    mst.frame(32, psr_pkg::OP_WRITE, ADDR, regn, wd, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    $display("FAIL at %0t: run did not finish in time", $time);
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    arst_n          = 1'b1;
    line_st.link_up = 1'b1;
    tick(4);
    rd_chk(psr_pkg::REG_STATUS, stat(F, F, F, F));
    rd_chk(psr_pkg::REG_STATUS, stat(F, F, T, F));
    // Idle bit closing the last frame counts as one preamble one: 30 more make 31
    mst.frame(30, psr_pkg::OP_READ, ADDR, psr_pkg::REG_STATUS, 16'h0000, rd);
    check(rd, 16'hFFFF);
    mst.frame(32, psr_pkg::OP_READ, 5'h04, psr_pkg::REG_STATUS, 16'h0000, rd);
    check(rd, 16'hFFFF);
    rd_chk(5'h04, 16'h0000);
    $display("Test reset_and_refusal done");

    line_st.an_done = 1'b1;
    tick(2);
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, F));
    for (int i = 0; i < 4; i++) begin
      lp_word  = lp_tab[i];
      lp_valid = 1'b1;
      tick(1);
      lp_valid = 1'b0;
      tick(2);
      rd_chk(psr_pkg::REG_STATUS, stat(T, i < 3, T, F));
      rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, F));
    end
    $display("Test remote_fault done");

    line_st.jabber = 1'b1;
    tick(3);
    line_st.jabber = 1'b0;
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, F));
    line_st.ten_tp  = 1'b1;
    line_st.jabber  = 1'b1;
    tick(3);
    line_st.jabber  = 1'b0;
    line_st.link_up = 1'b0;
    tick(3);
    line_st.link_up = 1'b1;
    wr(psr_pkg::REG_STATUS, 16'h0000);
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, F, T));
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, F));
    line_st.jabber = 1'b1;
    tick(2);
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, T));
    rd_chk(psr_pkg::REG_STATUS, stat(T, F, T, T));
    line_st.jabber  = 1'b0;
    line_st.an_done = 1'b0;
    rd_chk(psr_pkg::REG_STATUS, stat(F, F, T, T));
    rd_chk(psr_pkg::REG_STATUS, stat(F, F, T, F));
    $display("Test latched_flags done");

    // Identifier bit n sits at index n-1 of the parameter
    for (int j = 0; j < 16; j++) id_hi[15-j] = psr_pkg::OUI_NEUTRAL[2+j];
    id_lo = {6'h00, psr_pkg::MODEL_NEUTRAL, psr_pkg::REV_NEUTRAL};
    for (int k = 0; k < 6; k++) id_lo[15-k] = psr_pkg::OUI_NEUTRAL[18+k];
    wr(psr_pkg::REG_ID_HIGH, ~id_hi);
    wr(psr_pkg::REG_ID_LOW, ~id_lo);
    rd_chk(psr_pkg::REG_ID_HIGH, id_hi);
    rd_chk(psr_pkg::REG_ID_LOW, id_lo);
    $display("Test identifiers done");
    end_of_test();
  end
endmodule
